// file: awtp_top.sv
// trigger unit, multi-purpose line routing, four pulse generators, amp path
// assumes a 25 MHz clk, APB master on the same clock, async trigger pins
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "awtp_defines.svh"
module awtp_top
	import awtp_pkg::*;
#(
	parameter int SWITCH_CYC = `AWTP_SWITCH_MS * `AWTP_CLK_KHZ
)(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        window_trigger_input,
	input  wire logic        level_trigger_input,
	input  wire logic        inst_armed,
	input  wire logic        inst_running,
	input  wire logic        marker,
	input  wire logic        loop_until_trigger_step,
	input  wire logic [2:0]  multipurpose_line_in,
	output logic      [2:0]  multipurpose_line_out,
	output logic      [2:0]  multipurpose_line_oe_n,
	output logic             card_trigger,
	output logic             output_start,
	output logic             trig_ready,
	output logic             amp_high_path,
	output logic             output_enable,
	output logic             filter_enable
);
	localparam int LAT_PAD = (`AWTP_LAT_PAD_NS * `AWTP_CLK_KHZ + 999999) / 1000000;
	localparam logic [9:0] LAT_LO = 10'((`AWTP_LAT_LO_X2 + 1) / 2 + LAT_PAD);
	localparam logic [9:0] LAT_HI = 10'((`AWTP_LAT_HI_X2 + 1) / 2 + LAT_PAD);

	// trigger edge match for the programmed polarity
	function automatic logic edge_hit(input logic cur, input logic prv, input logic [1:0] sel);
		edge_hit = (sel != ED_FALL && cur && !prv) || (sel != ED_RISE && !cur && prv);
	endfunction
	// clamp to [lo, hi] and round down to the step (step a power of two)
	function automatic logic [32:0] fit(input logic [32:0] v, lo, hi, step);
		logic [32:0] r;
		r = (v < lo) ? lo : ((v > hi) ? hi : v);
		fit = r & ~(step - 33'h1);
	endfunction

	logic        wr_en;
	logic        sw_trig;
	logic [2:0]  tmode;
	logic [1:0]  tedge;
	logic [27:0] tdly;
	logic [32:0] mem_depth;
	logic [32:0] seg_size;
	logic [2:0]  chans;
	logic [12:0] amp_mv;
	logic        hi_rate;
	logic [15:0] mpl_sel;
	logic [2:0]  mpl_sw;
	logic [31:0] pg_period [4];
	logic [31:0] pg_width  [4];
	logic [31:0] pg_delay  [4];
	logic [31:0] pg_loops  [4];
	logic [8:0]  pg_ctrl   [4];
	logic [3:0]  pg_swtrig;
	logic [32:0] mem_per_ch;
	assign wr_en = psel && penable && pwrite;
	assign pready = 1'b1;
	assign mem_per_ch = (chans == 3'h4) ? (`AWTP_MEM_SAMPLES >> 2) :
		(chans == 3'h2) ? (`AWTP_MEM_SAMPLES >> 1) : `AWTP_MEM_SAMPLES;

	// software-written configuration; zero wait state so one edge per access
	always_ff @(posedge clk) begin
		sw_trig <= 1'b0;
		pg_swtrig <= 4'h0;
		if (reset) begin
			tmode <= TM_EXT;
			tedge <= ED_RISE;
			tdly <= 28'h0;
			mem_depth <= 33'(`AWTP_DEPTH_STEP);
			seg_size <= 33'(`AWTP_SEG_STEP);
			chans <= 3'h1;
			amp_mv <= 13'h0;
			hi_rate <= 1'b0;
			filter_enable <= 1'b0;
			mpl_sel <= 16'h0;
			mpl_sw <= 3'h0;
			for (int g = 0; g < 4; g++) begin
				pg_period[g] <= 32'h2;
				pg_width[g] <= 32'h1;
				pg_delay[g] <= 32'h0;
				pg_loops[g] <= 32'h1;
				pg_ctrl[g] <= 9'h0;
			end
		end else if (wr_en) begin
			if (paddr == `AWTP_A_TRIG_CFG) begin
				tmode <= pwdata[2:0];
				tedge <= pwdata[4:3];
			end else if (paddr == `AWTP_A_TRIG_DLY) begin
				tdly <= pwdata[31:5] == 27'h0 ? 28'h0 : {1'b0, pwdata[31:5]};
			end else if (paddr == `AWTP_A_SW_TRIG) begin
				sw_trig <= pwdata[0];
				pg_swtrig <= pwdata[7:4];
			end else if (paddr == `AWTP_A_MEM_DEPTH) begin
				mem_depth <= fit({1'b0, pwdata}, 33'(`AWTP_DEPTH_STEP), mem_per_ch,
					33'(`AWTP_DEPTH_STEP));
			end else if (paddr == `AWTP_A_SEG_SIZE) begin
				seg_size <= fit({1'b0, pwdata}, 33'(`AWTP_SEG_STEP), mem_per_ch >> 1,
					33'(`AWTP_SEG_STEP));
			end else if (paddr == `AWTP_A_CHANNELS) begin
				chans <= (pwdata[2:0] == 3'h4 || pwdata[2:0] == 3'h2) ? pwdata[2:0] : 3'h1;
			end else if (paddr == `AWTP_A_AMP_MV) begin
				amp_mv <= pwdata[12:0];
			end else if (paddr == `AWTP_A_OUT_CFG) begin
				filter_enable <= pwdata[0];
				hi_rate <= pwdata[1];
			end else if (paddr == `AWTP_A_MPL_SEL) begin
				mpl_sel <= pwdata[15:0];
				mpl_sw <= pwdata[18:16];
			end else if (paddr[11:6] == `AWTP_A_PG_BASE >> 6) begin
				case (paddr[3:2])
					2'h0: pg_period[paddr[5:4]] <= pwdata < 32'h2 ? 32'h2 : pwdata;
					2'h1: pg_width[paddr[5:4]] <= pwdata < 32'h1 ? 32'h1 : pwdata;
					2'h2: pg_delay[paddr[5:4]] <= pwdata;
					default: pg_loops[paddr[5:4]] <= pwdata;
				endcase
			end else if (paddr[11:4] == `AWTP_A_PG_CTRL >> 4) begin
				pg_ctrl[paddr[3:2]] <= pwdata[8:0];
			end
		end
	end

	// three-stage pin synchronisers, level accepted when stages two and three agree
	logic [4:0] sy1, sy2, sy3, lvl;
	always_ff @(posedge clk) begin
		// lines idle high on their pull-ups, triggers idle low: no false edge after reset
		if (reset) begin
			sy1 <= 5'h1C;
			sy2 <= 5'h1C;
			sy3 <= 5'h1C;
			lvl <= 5'h1C;
		end else begin
			sy1 <= {multipurpose_line_in, level_trigger_input, window_trigger_input};
			sy2 <= sy1;
			sy3 <= sy2;
			// one clock resolution; short glitches filtered
			lvl <= (sy2 & sy3) | (lvl & (sy2 | sy3));
		end
	end

	// trigger source combination per mode
	logic comb, comb_prv, rearm_armed, raw_trig;
	always_comb begin
		case (tmode)
			TM_OR:   comb = lvl[0] | lvl[1];
			TM_AND:  comb = lvl[0] & lvl[1];
			TM_REARM: comb = lvl[1];
			default: comb = lvl[0];
		endcase
		if (tmode == TM_SW)
			raw_trig = sw_trig;
		else
			raw_trig = edge_hit(comb, comb_prv, tedge) && (tmode != TM_REARM || rearm_armed);
	end

	// re-arm: window input arms, level input edge fires
	always_ff @(posedge clk) begin
		if (reset) begin
			comb_prv <= 1'b0;
			rearm_armed <= 1'b0;
		end else begin
			comb_prv <= comb;
			if (lvl[0])
				rearm_armed <= 1'b1;
			else if (raw_trig && trig_ready)
				rearm_armed <= 1'b0;
		end
	end

	// trigger sequencer: delay, output latency, re-arm gap
	awtp_tstate_e tst;
	logic [32:0]  tcnt;
	assign trig_ready = (tst == TS_READY);
	always_ff @(posedge clk) begin
		card_trigger <= 1'b0;
		output_start <= 1'b0;
		if (reset) begin
			tst <= TS_READY;
			tcnt <= 33'h0;
		end else begin
			case (tst)
				TS_READY: if (raw_trig) begin
					tcnt <= {tdly, 5'h0};
					tst <= TS_DELAY;
				end
				TS_DELAY: if (tcnt == 33'h0) begin
					card_trigger <= 1'b1;
					tcnt <= loop_until_trigger_step ? 33'h0 : {23'h0, hi_rate ? LAT_HI : LAT_LO};
					tst <= TS_LAT;
				end else begin
					tcnt <= tcnt - 33'h1;
				end
				TS_LAT: if (tcnt <= 33'h1) begin
					output_start <= 1'b1;
					tcnt <= 33'(`AWTP_REARM_SMP - 1);
					tst <= TS_REARM;
				end else begin
					tcnt <= tcnt - 33'h1;
				end
				default: if (tcnt == 33'h0)
					tst <= TS_READY;
				else
					tcnt <= tcnt - 33'h1;
			endcase
		end
	end

	// amp path hysteresis; output off while switching
	logic [17:0] sw_cnt;
	always_ff @(posedge clk) begin
		if (reset) begin
			amp_high_path <= 1'b0;
			sw_cnt <= 18'h0;
		end else if (!amp_high_path && amp_mv >= 13'(`AWTP_AMP_UP_MV) ||
				amp_high_path && amp_mv <= 13'(`AWTP_AMP_DN_MV)) begin
			amp_high_path <= !amp_high_path;
			sw_cnt <= 18'(SWITCH_CYC);
		end else if (sw_cnt != 18'h0) begin
			sw_cnt <= sw_cnt - 18'h1;
		end
	end
	assign output_enable = (sw_cnt == 18'h0);

	// timebase tick from the sample clock
	logic [7:0] tb_cnt;
	logic       tb_tick;
	assign tb_tick = (tb_cnt == 8'h0);
	always_ff @(posedge clk) begin
		if (reset || tb_tick)
			tb_cnt <= 8'(`AWTP_PG_DIV - 1);
		else
			tb_cnt <= tb_cnt - 8'h1;
	end

	// four generators; ctrl: en[0] mode[2:1] src[4:3] idx[6:5] gate[8:7]
	awtp_pstate_e pst [4];
	logic [31:0] pcnt [4];
	logic [31:0] prem [4];
	logic [3:0]  pg_out, pg_prv, pg_trig, pg_gate;
	logic [2:0]  mpl_prv;
	always_comb begin
		for (int g = 0; g < 4; g++) begin
			case (pg_ctrl[g][4:3])
				PT_SW:   pg_trig[g] = pg_swtrig[g];
				PT_CARD: pg_trig[g] = card_trigger;
				PT_PG:   pg_trig[g] = pg_out[pg_ctrl[g][6:5]] && !pg_prv[pg_ctrl[g][6:5]];
				default: pg_trig[g] = pg_ctrl[g][6:5] != 2'h3 &&
					lvl[2 + pg_ctrl[g][6:5]] && !mpl_prv[pg_ctrl[g][6:5]];
			endcase
			case (pg_ctrl[g][8:7])
				PG_ARM:  pg_gate[g] = inst_armed;
				PG_RUN:  pg_gate[g] = inst_running;
				default: pg_gate[g] = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pg_prv <= 4'h0;
			mpl_prv <= 3'h7;
			for (int g = 0; g < 4; g++) begin
				pst[g] <= PS_IDLE;
				pcnt[g] <= 32'h0;
				prem[g] <= 32'h0;
			end
		end else begin
			pg_prv <= pg_out;
			mpl_prv <= lvl[4:2];
			for (int g = 0; g < 4; g++) begin
				if (!pg_ctrl[g][0] || (!pg_gate[g] && pg_ctrl[g][2:1] == PM_GATED)) begin
					pst[g] <= PS_IDLE;
				end else case (pst[g])
					PS_IDLE: if (pg_trig[g] && pg_gate[g]) begin
						pcnt[g] <= pg_delay[g];
						prem[g] <= pg_ctrl[g][2:1] == PM_SINGLE ? 32'h1 :
							pg_ctrl[g][2:1] == PM_GATED ? 32'h0 : pg_loops[g];
						pst[g] <= PS_DELAY;
					end
					PS_DELAY: if (tb_tick) begin
						// zero delay still costs this state's one tick, so each count adds one
						if (pcnt[g] == 32'h0) begin
							pcnt[g] <= pg_width[g];
							pst[g] <= PS_HIGH;
						end else
							pcnt[g] <= pcnt[g] - 32'h1;
					end
					PS_HIGH: if (tb_tick) begin
						if (pcnt[g] <= 32'h1) begin
							pcnt[g] <= pg_period[g] - pg_width[g];
							pst[g] <= PS_LOW;
						end else
							pcnt[g] <= pcnt[g] - 32'h1;
					end
					default: if (tb_tick) begin
						if (pcnt[g] <= 32'h1) begin
							pcnt[g] <= pg_width[g];
							prem[g] <= prem[g] - 32'h1;
							pst[g] <= (prem[g] == 32'h1) ? PS_IDLE : PS_HIGH;
						end else
							pcnt[g] <= pcnt[g] - 32'h1;
					end
				endcase
			end
		end
	end
	always_comb begin
		for (int g = 0; g < 4; g++)
			pg_out[g] = (pst[g] == PS_HIGH);
	end

	// line routing; sel nibble 0 input, 1..7 signals, 8..11 generators
	always_ff @(posedge clk) begin
		if (reset) begin
			multipurpose_line_out <= 3'h0;
			multipurpose_line_oe_n <= 3'h7;
		end else begin
			for (int l = 0; l < 3; l++) begin
				multipurpose_line_oe_n[l] <= (mpl_sel[4*l +: 4] == 4'h0);
				case (mpl_sel[4*l +: 4])
					4'h1, 4'h2: multipurpose_line_out[l] <= mpl_sw[l];
					4'h3: multipurpose_line_out[l] <= card_trigger;
					4'h4: multipurpose_line_out[l] <= inst_running;
					4'h5: multipurpose_line_out[l] <= inst_armed;
					4'h6: multipurpose_line_out[l] <= marker;
					4'h7: multipurpose_line_out[l] <= !multipurpose_line_out[l];
					4'h8, 4'h9, 4'hA, 4'hB: multipurpose_line_out[l] <= pg_out[mpl_sel[4*l +: 2]];
					default: multipurpose_line_out[l] <= 1'b0;
				endcase
			end
		end
	end

	// read mux; unmapped addresses answer with pslverr
	always_comb begin
		prdata = 32'h0;
		pslverr = 1'b0;
		if (paddr == `AWTP_A_TRIG_CFG)
			prdata = {27'h0, tedge, tmode};
		else if (paddr == `AWTP_A_TRIG_DLY)
			prdata = {tdly[26:0], 5'h0};
		else if (paddr == `AWTP_A_SW_TRIG)
			prdata = 32'h0;
		else if (paddr == `AWTP_A_STATUS)
			prdata = {25'h0, lvl[4:2], output_enable, amp_high_path, rearm_armed, trig_ready};
		else if (paddr == `AWTP_A_MEM_DEPTH)
			prdata = mem_depth[31:0];
		else if (paddr == `AWTP_A_SEG_SIZE)
			prdata = seg_size[31:0];
		else if (paddr == `AWTP_A_CHANNELS)
			prdata = {29'h0, chans};
		else if (paddr == `AWTP_A_AMP_MV)
			prdata = {19'h0, amp_mv};
		else if (paddr == `AWTP_A_OUT_CFG)
			prdata = {30'h0, hi_rate, filter_enable};
		else if (paddr == `AWTP_A_MPL_SEL)
			prdata = {13'h0, mpl_sw, mpl_sel};
		else if (paddr == `AWTP_A_PG_TBASE)
			prdata = 32'(`AWTP_PG_DIV);
		else if (paddr[11:6] == `AWTP_A_PG_BASE >> 6)
			prdata = paddr[3:2] == 2'h0 ? pg_period[paddr[5:4]] : paddr[3:2] == 2'h1 ?
				pg_width[paddr[5:4]] : paddr[3:2] == 2'h2 ? pg_delay[paddr[5:4]] : pg_loops[paddr[5:4]];
		else if (paddr[11:4] == `AWTP_A_PG_CTRL >> 4)
			prdata = {23'h0, pg_ctrl[paddr[3:2]]};
		else
			pslverr = psel && penable;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_fired;
		tst == TS_READY && raw_trig;
	endsequence
	sequence s_done;
		output_start;
	endsequence
	chk_trig_edge: assert property ((tmode == TM_EXT || tmode == TM_WINDOW) && tedge == ED_RISE &&
		tst == TS_READY && lvl[0] && !comb_prv |=> tst == TS_DELAY) else $error("rising edge missed");
	chk_rearm_gap: assert property (s_done |=> !trig_ready [*8]) else $error("re-arm too early");
	chk_rearm_end: assert property (s_done |-> ##40 trig_ready) else $error("re-arm late");
	chk_dly_zero: assert property (s_fired ##0 tdly == 28'h0 |-> ##2 card_trigger)
		else $error("zero delay wrong");
	chk_lat_lo: assert property (card_trigger && !hi_rate && !loop_until_trigger_step |->
		##240 output_start) else $error("latency wrong");
	chk_amp_up: assert property (!amp_high_path && amp_mv >= 13'(`AWTP_AMP_UP_MV) |=>
		amp_high_path && !output_enable) else $error("amp path not raised");
	chk_amp_hold: assert property (amp_high_path && amp_mv > 13'(`AWTP_AMP_DN_MV) |=> amp_high_path)
		else $error("hysteresis broken");
	chk_out_off: assert property ($rose(amp_high_path) |-> !output_enable [*8]) else $error("output on");
	chk_depth_step: assert property (mem_depth[4:0] == 5'h0 && mem_depth >= 33'h20)
		else $error("depth misaligned");
	chk_seg_step: assert property (seg_size[3:0] == 4'h0 && seg_size >= 33'h10)
		else $error("segment misaligned");
	chk_mpl_in: assert property (mpl_sel[3:0] == 4'h0 |=> multipurpose_line_oe_n[0])
		else $error("input line driven");
endmodule

// file: awtp_defines.svh
// register offsets, step sizes and timing counts
// assumes a 25 MHz sample clock and 32-bit word aligned APB addressing
`ifndef AWTP_DEFINES_SVH
`define AWTP_DEFINES_SVH
`define AWTP_A_TRIG_CFG   12'h000
`define AWTP_A_TRIG_DLY   12'h004
`define AWTP_A_SW_TRIG    12'h008
`define AWTP_A_STATUS     12'h00C
`define AWTP_A_MEM_DEPTH  12'h010
`define AWTP_A_SEG_SIZE   12'h014
`define AWTP_A_CHANNELS   12'h018
`define AWTP_A_AMP_MV     12'h01C
`define AWTP_A_OUT_CFG    12'h020
`define AWTP_A_MPL_SEL    12'h024
`define AWTP_A_PG_TBASE   12'h028
`define AWTP_A_PG_BASE    12'h040
`define AWTP_A_PG_CTRL    12'h080
`define AWTP_DLY_STEP     32
`define AWTP_DEPTH_STEP   32
`define AWTP_SEG_STEP     16
`define AWTP_REARM_SMP    40
`define AWTP_LAT_LO_X2    477
`define AWTP_LAT_HI_X2    953
`define AWTP_LAT_PAD_NS   16
`define AWTP_CLK_KHZ      25000
`define AWTP_AMP_UP_MV    480
`define AWTP_AMP_DN_MV    420
`define AWTP_SWITCH_MS    10
`define AWTP_PG_DIV       1
`define AWTP_MEM_SAMPLES  33'h080000000
`endif

// file: awtp_pkg.sv
// types shared by the trigger and pulse generator block
package awtp_pkg;
	typedef enum logic [2:0] {TM_EXT, TM_SW, TM_WINDOW, TM_REARM, TM_OR, TM_AND} awtp_tmode_e;
	typedef enum logic [1:0] {ED_RISE, ED_FALL, ED_BOTH} awtp_edge_e;
	typedef enum {TS_READY, TS_DELAY, TS_LAT, TS_REARM} awtp_tstate_e;
	typedef enum {PS_IDLE, PS_DELAY, PS_HIGH, PS_LOW} awtp_pstate_e;
	typedef enum logic [1:0] {PM_SINGLE, PM_REPEAT, PM_GATED} awtp_pmode_e;
	typedef enum logic [1:0] {PT_SW, PT_CARD, PT_PG, PT_MPL} awtp_psrc_e;
	typedef enum logic [1:0] {PG_NONE, PG_ARM, PG_RUN} awtp_gate_e;
endpackage

// file: awtp_ext_model.sv
// external trigger source and front-plate equipment facing the block
// assumes the bench calls its tasks from a process synchronous to clk
`timescale 1ns/10ps
module awtp_ext_model (
	input  wire logic       clk,
	output logic            window_trig,
	output logic            level_trig,
	output logic      [2:0] line_drv
);
	// idle comparators low, front lines pulled up to 3.3 V
	initial begin
		window_trig = 1'b0;
		level_trig  = 1'b0;
		line_drv    = 3'b111;
	end

	// minimum pulse hold
	// a pulse shorter than two samples could be missed, so clamp it
	task automatic pulse(input int width);
		int w;
		w = (width < 2) ? 2 : width;
		@(posedge clk);
		window_trig <= 1'b1;
		repeat (w) @(posedge clk);
		window_trig <= 1'b0;
	endtask

	// equipment levels on the three lines
	task automatic set_lines(input logic [2:0] v);
		@(posedge clk);
		line_drv <= v;
	endtask
endmodule

// file: tb_top.sv
// self-checking bench for the trigger and pulse generator block
// assumes the design answers APB with zero wait and one shared clock
`timescale 1ns/10ps
`include "awtp_defines.svh"
module tb_top;
	import awtp_pkg::*;
	localparam int SW_CYC  = 20;
	localparam int PIN_LAT = 7;
	localparam int LAT_LO  = (`AWTP_LAT_LO_X2 + 1) / 2 + 1;
	localparam int LAT_HI  = (`AWTP_LAT_HI_X2 + 1) / 2 + 1;
	localparam int REARM   = `AWTP_REARM_SMP;
	localparam int LIMIT   = 12000;
	localparam logic [11:0] ADR [4] = '{`AWTP_A_MEM_DEPTH, `AWTP_A_MEM_DEPTH, `AWTP_A_SEG_SIZE, `AWTP_A_SEG_SIZE};
	localparam logic [31:0] WV [4]  = '{32'h5, 32'h64, 32'h3, 32'h28};
	localparam logic [31:0] RV [4]  = '{32'h20, 32'h60, 32'h10, 32'h20};
	localparam logic [3:0]  SEL [4] = '{4'h2, 4'h4, 4'h5, 4'h6};
	typedef struct {logic [31:0] d; logic err;} awtp_rd_s;
	logic        clk, reset, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, seed;
	logic        inst_armed, inst_running, marker, loop_step, amp_exp;
	logic [2:0]  line_out, oe_n, line_drv, mpl_wire;
	logic        card_trigger, output_start, trig_ready, amp_high_path, output_enable, filter_enable;
	logic        window_trig, level_trig;
	int          mismatches, compares, cyc, t_ref, last_ct, n, h, r;
	awtp_rd_s    rd_q[$];
	awtp_rd_s    e_mon;
	int          ct_q[$];
	int          lat_q[$];

	// wire level: design drives when its enable is low, else the equipment
	assign mpl_wire = (~oe_n & line_out) | (oe_n & line_drv);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	awtp_top #(.SWITCH_CYC(SW_CYC)) dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.window_trigger_input(window_trig), .level_trigger_input(level_trig), .inst_armed(inst_armed),
		.inst_running(inst_running), .marker(marker), .loop_until_trigger_step(loop_step),
		.multipurpose_line_in(mpl_wire), .multipurpose_line_out(line_out), .multipurpose_line_oe_n(oe_n),
		.card_trigger(card_trigger), .output_start(output_start), .trig_ready(trig_ready),
		.amp_high_path(amp_high_path), .output_enable(output_enable), .filter_enable(filter_enable));

	awtp_ext_model src (.clk(clk), .window_trig(window_trig), .level_trig(level_trig), .line_drv(line_drv));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic stop_test();
		$display("mismatches=%0d compares=%0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic cmp_rd(input logic [31:0] got, input logic ge, input awtp_rd_s e);
		compares++;
		if (got !== e.d || ge !== e.err) begin
			mismatches++;
			$display("[FAIL] %0t read %h/%b expected %h/%b", $time, got, ge, e.d, e.err);
		end
	endtask

	task automatic cmp_cnt(input int got, input int exp, input string what);
		compares++;
		if (got != exp) begin
			mismatches++;
			$display("[FAIL] %0t %s count %0d expected %0d", $time, what, got, exp);
		end
	endtask

	task automatic cmp_lvl(input logic got, input logic exp, input string what);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s level %b expected %b", $time, what, got, exp);
		end
	endtask

	// one transfer; the expected answer is queued for the monitor
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] ed, input logic ee);
		awtp_rd_s e;
		e.d = ed;
		e.err = ee;
		rd_q.push_back(e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// hold the access phase until the slave answers; only the bench timeout ends a hang
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
		apb(1'b1, a, d, 32'h0, ee);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic ee);
		apb(1'b0, a, 32'h0, ed, ee);
	endtask

	// amplitude step: expected path follows the hysteresis band
	task automatic amp_step(input int mv);
		logic nh;
		int k;
		nh = (mv >= `AWTP_AMP_UP_MV) ? 1'b1 : ((mv <= `AWTP_AMP_DN_MV) ? 1'b0 : amp_exp);
		wr(`AWTP_A_AMP_MV, mv[31:0], 1'b0);
		k = 0;
		if (nh != amp_exp) begin
			while (output_enable !== 1'b0 && k < 10) begin
				@(negedge clk);
				k++;
			end
			k = 0;
			while (output_enable === 1'b0 && k < 1000) begin
				@(negedge clk);
				k++;
			end
			cmp_cnt(k, SW_CYC, "switch time");
		end else begin
			repeat (SW_CYC) begin
				@(negedge clk);
				if (output_enable !== 1'b1)
					k++;
			end
			cmp_cnt(k, 0, "needless switch");
		end
		amp_exp = nh;
		repeat (2) @(negedge clk);
		cmp_lvl(amp_high_path, amp_exp, "amp path");
	endtask

	// counts high cycles and rising edges on line 0
	task automatic count_line(input int cycles, output int highs, output int rises);
		logic prev;
		prev = (line_out[0] === 1'b1);
		highs = 0;
		rises = 0;
		repeat (cycles) begin
			@(negedge clk);
			if (line_out[0] === 1'b1)
				highs++;
			if (line_out[0] === 1'b1 && !prev)
				rises++;
			prev = (line_out[0] === 1'b1);
		end
	endtask

	// monitor: takes the oldest note whenever a result appears
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && rd_q.size() > 0) begin
			e_mon = rd_q.pop_front();
			cmp_rd(pwrite ? e_mon.d : prdata, pslverr, e_mon);
		end
		if (card_trigger === 1'b1) begin
			last_ct = cyc;
			if (ct_q.size() > 0 && ct_q[0] < 0)
				void'(ct_q.pop_front());
			else if (ct_q.size() > 0)
				cmp_cnt(cyc - t_ref, ct_q.pop_front(), "trigger time");
			else
				cmp_cnt(1, 0, "stray card trigger");
		end
		if (output_start === 1'b1) begin
			if (lat_q.size() > 0)
				cmp_cnt(cyc - last_ct, lat_q.pop_front(), "output latency");
			else
				cmp_cnt(1, 0, "stray output start");
		end
		if (cyc > LIMIT) begin
			mismatches++;
			stop_test();
		end
	end

	initial begin
		seed = 32'hAA0D99C1;
		{reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 3'b000, 12'h000, 32'h0};
		{inst_armed, inst_running, marker, loop_step, amp_exp} = 5'b00000;
		{mismatches, compares, cyc, t_ref, last_ct} = {5{32'sd0}};
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		// map basics, refused places, clamped sizes, delay granularity
		rd(`AWTP_A_PG_TBASE, `AWTP_PG_DIV, 1'b0);
		rd(12'h030, 32'h0, 1'b1);
		wr(12'h3FC, 32'hFFFFFFFF, 1'b1);
		for (int i = 0; i < 4; i++) begin
			wr(ADR[i], WV[i], 1'b0);
			rd(ADR[i], RV[i], 1'b0);
		end
		for (int i = 0; i < 3; i++) begin
			pwdata <= pwdata;
			wr(`AWTP_A_TRIG_DLY, rnd(), 1'b0);
			rd(`AWTP_A_TRIG_DLY, seed & 32'hFFFFFFE0, 1'b0);
		end
		wr(`AWTP_A_TRIG_DLY, 32'h0, 1'b0);
		for (int f = 1; f >= 0; f--) begin
			wr(`AWTP_A_OUT_CFG, 32'(f), 1'b0);
			@(negedge clk);
			cmp_lvl(filter_enable, f[0], "filter");
		end
		// amplitude band edges first, then random levels around the band
		foreach (WV[i]) amp_step(i == 0 ? 479 : (i == 1 ? 480 : (i == 2 ? 421 : 420)));
		repeat (6) amp_step(400 + int'(rnd() % 32'd101));
		src.set_lines(3'(rnd()));
		repeat (6) @(posedge clk);
		rd(`AWTP_A_STATUS, {25'h0, line_drv, 1'b1, amp_exp, 2'b01}, 1'b0);
		// software level, running, armed and marker must each reach line 0, the others held opposite
		for (int k = 0; k < 4; k++) for (int v = 0; v < 2; v++) begin
			wr(`AWTP_A_MPL_SEL, {13'h0, 2'b00, (k == 0) == v[0], 12'h0, SEL[k]}, 1'b0);
			inst_running <= (k == 1) == v[0];
			inst_armed <= (k == 2) == v[0];
			marker <= (k == 3) == v[0];
			repeat (3) @(negedge clk);
			cmp_lvl(line_out[0], v[0], "routed line");
			cmp_lvl(oe_n[0], 1'b0, "line drive");
		end
		{inst_running, inst_armed, marker} <= 3'b000;
		// each generator: period 5, width 2, no delay, g+1 loops
		for (int g = 0; g < 4; g++) begin
			wr(`AWTP_A_MPL_SEL, 32'(8 + g), 1'b0);
			wr(`AWTP_A_PG_BASE + 12'(16 * g), 32'h5, 1'b0);
			wr(`AWTP_A_PG_BASE + 12'(16 * g + 4), 32'h2, 1'b0);
			wr(`AWTP_A_PG_BASE + 12'(16 * g + 8), 32'h0, 1'b0);
			wr(`AWTP_A_PG_BASE + 12'(16 * g + 12), 32'(g + 1), 1'b0);
			wr(`AWTP_A_PG_CTRL + 12'(4 * g), 32'h3, 1'b0);
			cmp_lvl(oe_n === 3'b110, 1'b1, "generator route");
			wr(`AWTP_A_SW_TRIG, 32'h10 << g, 1'b0);
			count_line(60, h, r);
			cmp_cnt(r, g + 1, "pulse count");
			cmp_cnt(h, 2 * (g + 1), "high time");
		end
		// zero loops keeps running until disabled
		wr(`AWTP_A_PG_BASE + 12'h03C, 32'h0, 1'b0);
		wr(`AWTP_A_SW_TRIG, 32'h80, 1'b0);
		count_line(20, h, r);
		count_line(50, h, r);
		cmp_cnt(r, 10, "endless pulses");
		wr(`AWTP_A_PG_CTRL + 12'h00C, 32'h0, 1'b0);
		count_line(20, h, r);
		count_line(20, h, r);
		cmp_cnt(h, 0, "disabled generator");
		// window pin with each edge choice, a 400 cycle pulse
		for (int e = 0; e < 4; e++) begin
			wr(`AWTP_A_TRIG_DLY, (e == 3) ? 32'h40 : 32'h0, 1'b0);
			wr(`AWTP_A_TRIG_CFG, 32'(2 + ((e % 3) << 3)), 1'b0);
			if (e != 1) ct_q.push_back(PIN_LAT + ((e == 3) ? 64 : 0));
			if (e == 1 || e == 2) ct_q.push_back(PIN_LAT + 400);
			repeat ((e == 2) ? 2 : 1) lat_q.push_back(LAT_LO);
			@(posedge clk);
			t_ref = cyc + 1;
			src.pulse(400);
			repeat (700) @(posedge clk);
		end
		wr(`AWTP_A_TRIG_DLY, 32'h0, 1'b0);
		// software trigger at both rates, then in loop-until-trigger step; a second one while busy is dropped
		for (int q = 0; q < 3; q++) begin
			wr(`AWTP_A_OUT_CFG, 32'(q << 1), 1'b0);
			wr(`AWTP_A_TRIG_CFG, 32'h1, 1'b0);
			loop_step <= (q == 2);
			ct_q.push_back(-1);
			lat_q.push_back(q == 2 ? 1 : (q ? LAT_HI : LAT_LO));
			wr(`AWTP_A_SW_TRIG, 32'h1, 1'b0);
			wr(`AWTP_A_SW_TRIG, 32'h1, 1'b0);
			n = 0;
			while (output_start !== 1'b1 && n < 1000) begin
				@(negedge clk);
				n++;
			end
			n = 0;
			while (trig_ready !== 1'b1 && n < 100) begin
				@(negedge clk);
				n++;
			end
			cmp_cnt(n, REARM, "re-arm time");
		end
		// reset again mid-run: configuration and line drivers return to idle
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rd(`AWTP_A_TRIG_CFG, 32'h0, 1'b0);
		cmp_lvl(oe_n === 3'h7, 1'b1, "line release");
		repeat (5) @(posedge clk);
		cmp_cnt(rd_q.size() + ct_q.size() + lat_q.size(), 0, "results missing");
		stop_test();
	end
endmodule
